// >>> src/sacr_convert_ctrl.v
// Overview of operation
// RL1: host holds start high at least 500 ns
// RL2: start rise resets sequencer, clears result, ready high
// RL3: approximation begins on start fall, 10-30 us
// RL4: ready flag falls when result is valid
// RL5: ready rises within 1.5 us of start
// RL6: ready rise slower when previous lsb set
// RL7: host keeps output enable high during conversion
// RL8: enable during conversion shows partial approximation value
// RL9: data driven only while output enable low
// RL10: blind host waits 30 us before reading
// RL11: host may poll or interrupt on ready
// RL12: write strobe and address form start pulse
// RL13: read strobe and address assert output enable
// RL14: stretcher flip-flop holds start until ready rises
// RL15: short start pulses work typically, not assured; here a pulse that ends before ready rises is always lost
// RL16: final result held until next start rise
`timescale 1ns/1ps
`default_nettype none
`include "sacr_defines.vh"

module sacr_convert_ctrl #(
    parameter RDY_RISE_NS   = `SACR_RDY_RISE_NS,
    parameter RDY_EXTRA_NS  = `SACR_RDY_LSB_EXTRA_NS,
    parameter CONV_NS       = `SACR_CONV_NS
) (
    input  wire                    core_clk,
    input  wire                    rst,
    input  wire                    start,
    input  wire                    output_enable_n,
    input  wire [`SACR_DATA_W-1:0] comp_in,
    output reg                     result_ready_n,
    output reg  [`SACR_DATA_W-1:0] data_out,
    output wire [`SACR_DATA_W-1:0] data_oe_n,
    output wire                    converting
);

    localparam W = `SACR_DATA_W;
    localparam CW = 16;
    // cycle counts derived from the ns figures; a ready rise is a least
    // delay of internal reset so round up, bit step rounds down
    localparam integer RISE_CYC  = (RDY_RISE_NS * `SACR_CLK_MHZ + 999) / 1000;
    localparam integer EXTRA_CYC = (RDY_EXTRA_NS * `SACR_CLK_MHZ + 999) / 1000;
    localparam integer STEP_CYC  = `SACR_NS2CYC(CONV_NS) / W;
    // loads are one less than the count, since expiry at zero also ticks;
    // cut to the timer width on purpose, all counts fit in CW bits
    localparam integer  RISE_M1  = RISE_CYC - 1;
    localparam integer  EXTRA_M1 = RISE_CYC + EXTRA_CYC - 1;
    localparam integer  STEP_M1  = STEP_CYC - 1;
    localparam [CW-1:0] RISE_LD  = RISE_M1[CW-1:0];
    localparam [CW-1:0] EXTRA_LD = EXTRA_M1[CW-1:0];
    localparam [CW-1:0] STEP_LD  = STEP_M1[CW-1:0];

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_RESET = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;
    localparam [1:0] ST_CONV  = 2'h3;

    reg  [1:0]   state_q;
    reg  [1:0]   state_d;
    reg          start_q;
    reg  [W-1:0] approximation_register_q;
    reg  [W-1:0] probe_q;
    reg  [W-1:0] result_q;
    reg          load;
    reg [CW-1:0] load_val;
    wire         tick;
    wire         start_rise;
    wire         start_fall;

    ////////////////////////////////////////////////////////////////////////
    // edge detect on the start line, taken as synchronous
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start;
        end
    end

    assign start_rise = start && !start_q;
    assign start_fall = !start && start_q;

    sacr_bit_timer #(
        .CNT_W (CW)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (load),
        .load_val (load_val),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer; a new rising start aborts anything in flight
    always @* begin
        state_d  = state_q;
        load     = 1'b0;
        load_val = STEP_LD;
        if (start_rise) begin
            state_d  = ST_RESET;                               // [RL2]
            load     = 1'b1;
            load_val = result_q[0] ? EXTRA_LD : RISE_LD;       // [RL5] [RL6]
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_RESET: begin
                    if (tick) begin
                        state_d = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // only a fall seen here starts; a pulse that ends during ST_RESET is lost [RL15]
                    if (start_fall) begin
                        state_d = ST_CONV;                     // [RL3]
                        load    = 1'b1;
                    end
                end
                ST_CONV: begin
                    if (tick && probe_q[0]) begin
                        state_d = ST_IDLE;                     // [RL4]
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // approximation register, ready flag and held result
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q                  <= ST_IDLE;
            approximation_register_q <= `SACR_RESULT_CLR;
            probe_q                  <= `SACR_RESULT_CLR;
            result_q                 <= `SACR_RESULT_CLR;
            result_ready_n           <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start_rise) begin
                approximation_register_q <= `SACR_RESULT_CLR;  // [RL2]
                result_q                 <= `SACR_RESULT_CLR;
            end else if (state_q == ST_RESET && tick) begin
                result_ready_n <= 1'b1;                        // [RL5]
            end else if (state_q == ST_WAIT && start_fall) begin
                probe_q                  <= {1'b1, {(W-1){1'b0}}};
                approximation_register_q <= {1'b1, {(W-1){1'b0}}};
            end else if (state_q == ST_CONV && tick) begin
                // keep the trial bit when the comparator says input is at or above it
                approximation_register_q <=
                    (comp_in >= approximation_register_q)
                    ? (approximation_register_q | (probe_q >> 1))
                    : ((approximation_register_q & ~probe_q)
                       | (probe_q >> 1));                      // [RL3]
                probe_q <= probe_q >> 1;
                if (probe_q[0]) begin
                    result_q       <= (comp_in >= approximation_register_q)
                                      ? approximation_register_q
                                      : (approximation_register_q & ~probe_q);
                    result_ready_n <= 1'b0;                    // [RL4] [RL16]
                end
            end
        end
    end

    assign converting = (state_q != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // output stage; while converting the partial value leaks out, which is
    // what the host must avoid by keeping the enable high
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_out <= `SACR_RESULT_CLR;
        end else if (converting) begin
            data_out <= approximation_register_q;              // [RL8]
        end else begin
            data_out <= result_q;                              // [RL16]
        end
    end

    // per-bit enable, low while driving
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_oe
            assign data_oe_n[gi] = output_enable_n;            // [RL9]
        end
    endgenerate

endmodule

`default_nettype wire

// >>> src/sacr_defines.vh
`ifndef SACR_DEFINES_VH
`define SACR_DEFINES_VH

// clock rate in MHz, core_clk
`define SACR_CLK_MHZ          100
// conversion start pulse least width, ns
`define SACR_START_MIN_NS     500
// ready-flag rise delay after start rises, ns (typ 1000, max 1500)
`define SACR_RDY_RISE_NS      1000
// extra rise delay when previous lsb was one, ns
`define SACR_RDY_LSB_EXTRA_NS 100
// conversion time, ns (min 10000, typ 20000, max 30000)
`define SACR_CONV_NS          20000
// cycles per ns figure: ns * mhz / 1000
`define SACR_NS2CYC(ns)       (((ns) * `SACR_CLK_MHZ) / 1000)
// result width
`define SACR_DATA_W           8
// empty result after reset or start
`define SACR_RESULT_CLR       8'h00

`endif

// >>> src/sacr_bit_timer.v
`timescale 1ns/1ps
`default_nettype none

// down counter that paces the approximation, one tick per bit step
module sacr_bit_timer #(
    parameter CNT_W = 16
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire             load,
    input  wire [CNT_W-1:0] load_val,
    output wire             tick
);

    reg [CNT_W-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // reload on load or on expiry, so ticks are evenly spaced
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {CNT_W{1'b0}};
        end else if (load || tick) begin
            cnt_q <= load_val;
        end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign tick = (cnt_q == {CNT_W{1'b0}}) && !load;

endmodule

`default_nettype wire

// >>> test/sacr_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sacr_checker (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       start,
    input wire logic       output_enable_n,
    input wire logic       result_ready_n,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic       converting
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ready holds a while after start falls, then drops inside the window
    sequence s_conv;
        result_ready_n [*8] ##[40:120] !result_ready_n;
    endsequence
    a_oe_follow: assert property (data_oe_n == {8{output_enable_n}})
        else $error("enable mismatch");
    a_rise_clear: assert property ($rose(start) |-> ##[0:2]
        (converting && data_out == 8'h00)) else $error("no clear");
    a_rdy_bound: assert property ($rose(start) |-> ##[1:150] result_ready_n)
        else $error("ready late");
    a_rdy_hold: assert property (start && result_ready_n |=> result_ready_n)
        else $error("ready dropped");
    a_conv_span: assert property ($fell(start) && result_ready_n |=> s_conv)
        else $error("conversion time");
    a_result_keep: assert property (!result_ready_n && !start
        && $past(!result_ready_n) |=> $stable(data_out)) else $error("moved");
    a_partial_out: assert property ($fell(start) && result_ready_n
        |=> ##1 (converting && data_out != 8'h00)) else $error("no partial");
    a_done_idle: assert property ($fell(result_ready_n) |-> ##[0:2] !converting)
        else $error("still busy");
endmodule
bind sacr_convert_ctrl sacr_checker u_chk (.core_clk(core_clk), .rst(rst),
    .start(start), .output_enable_n(output_enable_n),
    .result_ready_n(result_ready_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .converting(converting));
`default_nettype wire

// >>> test/sacr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sacr_host_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic addr_hit,
    input  wire logic wr_n,
    input  wire logic rd_n,
    input  wire logic result_ready_n,
    output var  logic start,
    output wire logic output_enable_n
);
    reg rdy_q;
    // read strobe on the decoded address opens the outputs
    assign output_enable_n = ~(addr_hit & ~rd_n);
    // short write sets the stretcher; ready rise clears it, data ignored
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= result_ready_n;
            if (addr_hit & ~wr_n)
                start <= 1'b1;
            else if (result_ready_n & ~rdy_q)
                start <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> test/sar_adc_convert_read_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_convert_read_control_bench;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    logic       addr_hit = 1'b0;
    logic       wr_n     = 1'b1;
    logic       rd_n     = 1'b1;
    logic [7:0] comp_in  = 8'h00;
    wire        start, output_enable_n, result_ready_n, converting;
    wire  [7:0] data_out, data_oe_n;
    int         n_fail, cmp_count, cyc, dly, rise, base;
    always #5 core_clk = ~core_clk;
    sacr_convert_ctrl #(.RDY_RISE_NS(50), .RDY_EXTRA_NS(20), .CONV_NS(800))
    dut (.core_clk(core_clk), .rst(rst), .start(start), .comp_in(comp_in),
        .output_enable_n(output_enable_n), .result_ready_n(result_ready_n),
        .data_out(data_out), .data_oe_n(data_oe_n), .converting(converting));
    sacr_host_model host (.core_clk(core_clk), .rst(rst), .addr_hit(addr_hit),
        .wr_n(wr_n), .rd_n(rd_n), .result_ready_n(result_ready_n),
        .start(start), .output_enable_n(output_enable_n));
    task automatic chk(input string nm, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    // bounded wait on the ready flag, cycles left in dly
    task automatic wait_rdy(input logic lvl);
        for (dly = 0; dly < 300 && result_ready_n !== lvl; dly++)
            @(negedge core_clk);
        if (dly >= 300) begin
            n_fail++;
            $display("unexpected ready wait exp %0d got timeout", lvl);
        end
    endtask
    // one short write strobe, then a read of the result
    task automatic t_convert(input logic [7:0] v);
        @(posedge core_clk);
        comp_in <= v;
        addr_hit <= 1'b1;
        wr_n <= 1'b0;
        @(posedge core_clk);
        wr_n <= 1'b1;
        wait_rdy(1'b1);
        rise = dly;
        chk("cleared", 8'h00, data_out);
        wait_rdy(1'b0);
        @(posedge core_clk);
        comp_in <= ~v;
        rd_n <= 1'b0;
        @(negedge core_clk);
        chk("oe low", 8'h00, data_oe_n);
        chk("result", v, data_out);
        @(posedge core_clk);
        rd_n <= 1'b1;
        @(negedge core_clk);
        chk("oe high", 8'hff, data_oe_n);
    endtask
    // the ready delay grows when the previous result ended in a one
    task automatic t_lsb_delay();
        logic [7:0] v [5] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h81};
        t_convert(v[0]);
        base = rise;
        for (int i = 1; i < 5; i++) begin
            t_convert(v[i]);
            chk("rise", 8'(base + (v[i-1][0] ? 2 : 0)), 8'(rise));
        end
    endtask
    // outputs opened mid-conversion drive the partial value
    task automatic t_peek();
        @(posedge core_clk);
        wr_n <= 1'b0;
        @(posedge core_clk);
        wr_n <= 1'b1;
        wait_rdy(1'b1);
        repeat (30) @(posedge core_clk);
        rd_n <= 1'b0;
        @(negedge core_clk);
        chk("peek", 8'h81, {~data_oe_n[0], 6'h00, converting});
        chk("partial", 8'h60, data_out);
        @(posedge core_clk);
        rd_n <= 1'b1;
        wait_rdy(1'b0);
    endtask
    // host that never looks at ready waits the longest conversion, then reads
    task automatic t_blind();
        @(posedge core_clk);
        comp_in <= 8'h3c;
        wr_n <= 1'b0;
        @(posedge core_clk);
        wr_n <= 1'b1;
        repeat (150) @(posedge core_clk);
        rd_n <= 1'b0;
        @(negedge core_clk);
        chk("blind", 8'h3c, data_out);
        chk("blind rdy", 8'h00, {7'h00, result_ready_n});
        @(posedge core_clk);
        rd_n <= 1'b1;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, well above the several hundred cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_lsb_delay();
        t_peek();
        t_blind();
        give_verdict();
    end
endmodule
`default_nettype wire
